// ---- hdl/crb_rx_lock.sv ----
/*
  Receive-slot locking, two temporary serial receive buffers, timestamping,
  done flags with interrupt, and engine clock selection under halt.
  Assumes frame events arrive synchronous to hclk from the protocol engine
  and osc_tick is a one-cycle pulse per oscillator clock period.
*/
// Notes on behaviour
// RULE1: Reading a slot's control/status word locks that slot against overwrite.
// RULE2: A frame for a locked slot is held pending in a temporary receive buffer.
// RULE3: A frame for a different slot while the first buffer is busy goes to the second; here only if that slot is locked or pending, else stored directly.
// RULE4: On unlock the slot gets the timestamp captured when its pending frame arrived.
// RULE5: Software should not lock a slot before its done flag is set.
// RULE6: Software should finish lock and unlock before end_of_frame_bit_six of the next frame.
// RULE7: Engine clock select resets to the oscillator clock; one selects the system clock.
// RULE8: Software should change the engine clock only while halted.
// RULE9: The halt write and the clock-select write take effect in different oscillator periods.
// RULE10: Software should not deactivate a slot near end_of_frame_bit_six after another unlock.
// RULE11: Software should deactivate a slot only when frozen or after the stated wait.
// RULE12: Software should leave an initialised slot's control/status word unwritten.
// RULE13: A slot's done flag is set at end_of_frame_bit_six of the frame stored into it.
// RULE14: Reading the free-running timer releases any locked slot.
// RULE15: Unlocking a slot with a pending frame moves it in and sets the done flag.
`timescale 1ns/1ps
module crb_rx_lock #(
  parameter int NSLOT = 16,
  parameter int SW    = 4
) (
  // Clock and reset
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  // AHB-Lite slave
  input  wire logic                      hsel,
  input  wire logic [11:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic                      hready,
  input  wire logic [31:0]               hwdata,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  // Frame events from the protocol engine
  input  wire logic                      frm_start,
  input  wire logic                      frm_end_of_frame_bit_six,
  input  wire logic                      frm_match,
  input  wire logic [SW-1:0]             frm_slot,
  input  wire logic [crb_pkg::DATA_W-1:0] frm_data,
  // Oscillator period marker
  input  wire logic                      osc_tick,
  // Engine control and interrupt
  output logic                           engine_halt,
  output logic                           engine_clock_select,
  output logic                           frm_lost,
  output logic                           irq
);
  import crb_pkg::*;

  localparam int MW = TS_W + DATA_W;

  // ****************************************
  // Bus address and data phase
  // ****************************************
  logic             acc;
  logic             dp_valid_reg;
  logic             dp_write_reg;
  logic [11:0]      dp_addr_reg;
  logic [NSLOT-1:0] done_reg;
  logic [NSLOT-1:0] mask_reg;
  logic [NSLOT-1:0] active_reg;
  logic             halt_reg;
  logic             clk_req_reg;
  logic             clk_sel_reg;
  logic             halt_seen_reg;
  logic             lock_valid_reg;
  logic [SW-1:0]    lock_slot_reg;
  logic [TS_W-1:0]  timer_reg;
  logic [TS_W-1:0]  ts_cap_reg;
  logic             tb_valid_reg [2];
  logic [SW-1:0]    tb_slot_reg  [2];
  logic [MW-1:0]    tb_word_reg  [2];
  logic [MW-1:0]    mem_rdata;

  function automatic logic is_slot(input logic [11:0] a);
    return (a >= OFS_SLOT_BASE) && (a < OFS_SLOT_BASE + 12'(NSLOT << SLOT_STRIDE_LG2));
  endfunction : is_slot

  function automatic logic [SW-1:0] slot_of(input logic [11:0] a);
    logic [11:0] off;
    off = a - OFS_SLOT_BASE;
    return off[SLOT_STRIDE_LG2 +: SW];
  endfunction : slot_of

  function automatic logic is_cs(input logic [11:0] a);
    return is_slot(a) && (a[2] == 1'b0);
  endfunction : is_cs

  assign acc       = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 12'h000;
    end else begin
      dp_valid_reg <= acc;
      dp_write_reg <= hwrite;
      dp_addr_reg  <= haddr;
    end
  end

  logic wr_dp;
  logic rd_ap;
  assign wr_dp = dp_valid_reg && dp_write_reg;
  assign rd_ap = acc && !hwrite;

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halt_reg    <= HALT_RST;
      clk_req_reg <= CLK_SEL_RST; // RULE7
      mask_reg    <= '0;
    end else if (wr_dp) begin
      if (dp_addr_reg == OFS_MODULE_CFG) begin
        halt_reg <= hwdata[HALT_BIT];
      end
      if (dp_addr_reg == OFS_CTRL) begin
        clk_req_reg <= hwdata[CLK_SEL_BIT];
      end
      if (dp_addr_reg == OFS_IRQ_MASK) begin
        mask_reg <= hwdata[NSLOT-1:0];
      end
    end
  end

  // ****************************************
  // Engine clock select
  // ****************************************
  // Halt must have been seen on an earlier oscillator period before the
  // select may move, so the two writes never act in the same period.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halt_seen_reg <= 1'b0;
      clk_sel_reg   <= CLK_SEL_RST; // RULE7
    end else begin
      if (!halt_reg) begin
        halt_seen_reg <= 1'b0;
      end else if (osc_tick) begin
        halt_seen_reg <= 1'b1; // RULE9
      end
      if (osc_tick && halt_seen_reg && halt_reg) begin
        clk_sel_reg <= clk_req_reg; // RULE9 RULE8
      end
    end
  end

  assign engine_halt         = halt_reg;
  assign engine_clock_select = clk_sel_reg;

  // ****************************************
  // Timer and lock
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_reg  <= '0;
      ts_cap_reg <= '0;
    end else begin
      timer_reg <= timer_reg + 1'b1;
      if (frm_start) begin
        ts_cap_reg <= timer_reg; // RULE4
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_valid_reg <= 1'b0;
      lock_slot_reg  <= '0;
    end else if (rd_ap && is_cs(haddr)) begin
      lock_valid_reg <= 1'b1; // RULE1
      lock_slot_reg  <= slot_of(haddr);
    end else if (rd_ap && haddr == OFS_TIMER) begin
      lock_valid_reg <= 1'b0; // RULE14
    end
  end

  function automatic logic locked(input logic [SW-1:0] s);
    return lock_valid_reg && (lock_slot_reg == s);
  endfunction : locked

  // ****************************************
  // Frame routing and temporary buffers
  // ****************************************
  logic          frm_ok;
  logic          hit0;
  logic          hit1;
  logic          to_tb;
  logic          direct;
  logic          mv0;
  logic          mv1;
  logic          mem_we;
  logic [SW-1:0] mem_wa;
  logic [MW-1:0] mem_wd;
  logic [MW-1:0] frm_word;

  assign frm_ok   = frm_end_of_frame_bit_six && frm_match && active_reg[frm_slot];
  assign frm_word = {ts_cap_reg, frm_data};
  assign hit0     = tb_valid_reg[0] && (tb_slot_reg[0] == frm_slot);
  assign hit1     = tb_valid_reg[1] && (tb_slot_reg[1] == frm_slot);
  // Process form, so a lock change read inside locked() wakes it
  always_comb begin
    // A slot with an older pending frame also queues, so order is kept
    to_tb    = frm_ok && (locked(frm_slot) || hit0 || hit1);
    direct   = frm_ok && !to_tb;
    // Moves wait while the engine stores directly, one write port only
    mv0      = !direct && tb_valid_reg[0] && !locked(tb_slot_reg[0]);
    mv1      = !direct && !mv0 && tb_valid_reg[1] && !locked(tb_slot_reg[1]);
    frm_lost = to_tb && !hit0 && !hit1 && tb_valid_reg[0] && tb_valid_reg[1];
  end

  always_comb begin
    mem_we = direct || mv0 || mv1;
    mem_wa = frm_slot;
    mem_wd = frm_word;
    if (mv0) begin
      mem_wa = tb_slot_reg[0]; // RULE15
      mem_wd = tb_word_reg[0]; // RULE4
    end else if (mv1) begin
      mem_wa = tb_slot_reg[1]; // RULE15
      mem_wd = tb_word_reg[1];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tb_valid_reg[0] <= 1'b0;
      tb_valid_reg[1] <= 1'b0;
      tb_slot_reg[0]  <= '0;
      tb_slot_reg[1]  <= '0;
      tb_word_reg[0]  <= '0;
      tb_word_reg[1]  <= '0;
    end else begin
      if (mv0) begin
        tb_valid_reg[0] <= 1'b0;
      end
      if (mv1) begin
        tb_valid_reg[1] <= 1'b0;
      end
      if (to_tb && (hit0 || !tb_valid_reg[0]) && !hit1) begin
        tb_valid_reg[0] <= 1'b1; // RULE2
        tb_slot_reg[0]  <= frm_slot;
        tb_word_reg[0]  <= frm_word;
      end else if (to_tb && (hit1 || !tb_valid_reg[1])) begin
        tb_valid_reg[1] <= 1'b1; // RULE3
        tb_slot_reg[1]  <= frm_slot;
        tb_word_reg[1]  <= frm_word;
      end
    end
  end

  crb_slot_mem #(
    .WIDTH (MW),
    .DEPTH (NSLOT),
    .AW    (SW)
  ) u_mem (
    .hclk    (hclk),
    .wr_en   (mem_we),
    .wr_addr (mem_wa),
    .wr_data (mem_wd),
    .rd_addr (slot_of(haddr)),
    .rd_data (mem_rdata)
  );

  // ****************************************
  // Slot state, done flags, interrupt
  // ****************************************
  logic [NSLOT-1:0] set_done;
  logic [NSLOT-1:0] clr_done;
  logic [NSLOT-1:0] cs_wr;

  always_comb begin
    set_done = '0;
    clr_done = '0;
    cs_wr    = '0;
    if (mem_we) begin
      set_done[mem_wa] = 1'b1; // RULE13 RULE15
    end
    if (wr_dp && dp_addr_reg == OFS_DONE_FLAGS) begin
      clr_done = hwdata[NSLOT-1:0];
    end
    if (wr_dp && is_cs(dp_addr_reg)) begin
      cs_wr[slot_of(dp_addr_reg)] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_reg   <= '0;
      active_reg <= '0;
    end else begin
      // Set wins over a write-one clear in the same cycle
      done_reg <= (done_reg & ~clr_done) | set_done;
      for (int i = 0; i < NSLOT; i++) begin
        if (cs_wr[i]) begin
          active_reg[i] <= hwdata[CODE_LSB +: 4] != CODE_INACTIVE;
        end
      end
    end
  end

  assign irq = |(done_reg & mask_reg);

  // ****************************************
  // Read data
  // ****************************************
  logic [SW-1:0] rs;
  logic [3:0]    code;
  assign rs   = slot_of(dp_addr_reg);
  assign code = !active_reg[rs] ? CODE_INACTIVE : (done_reg[rs] ? CODE_RX_FULL : CODE_RX_EMPTY);

  always_comb begin
    hrdata = 32'h0000_0000;
    if (dp_valid_reg && !dp_write_reg) begin
      if (is_slot(dp_addr_reg)) begin
        if (dp_addr_reg[2] == 1'b0) begin
          hrdata[CODE_LSB +: 4] = code;
          hrdata[TS_W-1:0]      = mem_rdata[MW-1 -: TS_W];
        end else begin
          hrdata = mem_rdata[DATA_W-1:0];
        end
      end else begin
        case (dp_addr_reg)
          OFS_MODULE_CFG: hrdata[HALT_BIT] = halt_reg;
          OFS_CTRL: begin
            hrdata[CLK_SEL_BIT]     = clk_req_reg;
            hrdata[CLK_APPLIED_BIT] = clk_sel_reg;
          end
          OFS_TIMER:      hrdata[TS_W-1:0] = timer_reg;
          OFS_DONE_FLAGS: hrdata[NSLOT-1:0] = done_reg;
          OFS_IRQ_MASK:   hrdata[NSLOT-1:0] = mask_reg;
          OFS_LOCK_STAT: begin
            hrdata[SW-1:0]         = lock_slot_reg;
            hrdata[LOCK_VALID_BIT] = lock_valid_reg;
            hrdata[TB0_BUSY_BIT]   = tb_valid_reg[0];
            hrdata[TB1_BUSY_BIT]   = tb_valid_reg[1];
          end
          default: hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  logic unused_ok;
  assign unused_ok = &{1'b0, hsize};
endmodule : crb_rx_lock

// ---- shared/crb_pkg.sv ----
/*
  Constants for the receive-slot lock and engine clock-select block.
  Assumes a 32-bit AHB-Lite register bus and 16 receive slots by default.
*/
package crb_pkg;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [11:0] OFS_MODULE_CFG  = 12'h000;
  localparam logic [11:0] OFS_CTRL        = 12'h004;
  localparam logic [11:0] OFS_TIMER       = 12'h008;
  localparam logic [11:0] OFS_DONE_FLAGS  = 12'h00c;
  localparam logic [11:0] OFS_IRQ_MASK    = 12'h010;
  localparam logic [11:0] OFS_LOCK_STAT   = 12'h014;
  localparam logic [11:0] OFS_SLOT_BASE   = 12'h100;
  localparam int          SLOT_STRIDE_LG2 = 3;

  // ****************************************
  // Field positions and codes
  // ****************************************
  localparam int          HALT_BIT       = 0;
  localparam int          CLK_SEL_BIT    = 0;
  localparam int          CLK_APPLIED_BIT = 1;
  localparam int          CODE_LSB       = 24;
  localparam logic [3:0]  CODE_INACTIVE  = 4'h0;
  localparam logic [3:0]  CODE_RX_EMPTY  = 4'h4;
  localparam logic [3:0]  CODE_RX_FULL   = 4'h2;
  localparam int          LOCK_VALID_BIT = 8;
  localparam int          TB0_BUSY_BIT   = 9;
  localparam int          TB1_BUSY_BIT   = 10;

  // ****************************************
  // Reset values and widths
  // ****************************************
  localparam logic        CLK_SEL_RST    = 1'b0;
  localparam logic        HALT_RST       = 1'b0;
  localparam int          TS_W           = 16;
  localparam int          DATA_W         = 32;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'b10;
endpackage : crb_pkg

// ---- hdl/crb_slot_mem.sv ----
/*
  Slot storage: one word of timestamp plus payload per receive slot.
  Assumes a single clock; read data is registered, one write port.
*/
`timescale 1ns/1ps
module crb_slot_mem #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // Clock
  input  wire logic             hclk,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read port
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge hclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // No reset on the array; read data is undefined until a slot is written
  always_ff @(posedge hclk) begin
    rd_data <= mem[rd_addr];
  end
endmodule : crb_slot_mem

// ---- tb/crb_rx_lock_monitor.sv ----
/*
  Port checker for crb_rx_lock, bound to every instance.
  Assumes one hclk domain and the map of crb_pkg.
*/
`timescale 1ns/1ps
module crb_rx_lock_monitor
  import crb_pkg::*;
#(
  parameter int NSLOT = 16,
  parameter int SW    = 4
) (
  // Clock and reset
  input wire logic              hclk,
  input wire logic              hresetn,
  // Bus
  input wire logic              hsel,
  input wire logic [11:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [2:0]        hsize,
  input wire logic              hready,
  input wire logic [31:0]       hwdata,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  // Frames
  input wire logic              frm_start,
  input wire logic              frm_end_of_frame_bit_six,
  input wire logic              frm_match,
  input wire logic [SW-1:0]     frm_slot,
  input wire logic [DATA_W-1:0] frm_data,
  input wire logic              osc_tick,
  // Outputs
  input wire logic              engine_halt,
  input wire logic              engine_clock_select,
  input wire logic              frm_lost,
  input wire logic              irq
);
  // ****************************************
  // Data phase tracking
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic ap;
  logic dph;
  logic cfgw;
  assign ap = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph  <= 1'b0;
      cfgw <= 1'b0;
    end else begin
      dph  <= ap;
      cfgw <= ap && hwrite && haddr == OFS_MODULE_CFG;
    end
  end
  a_reset_osc_clock: assert property (
    !$past(hresetn) |-> !engine_clock_select && !engine_halt)
    else $error("clock select or halt not clear after reset");
  a_select_on_tick: assert property (
    $changed(engine_clock_select) |-> $past(osc_tick) && $past(engine_halt))
    else $error("clock select moved off a halted tick");
  a_select_halt_seen: assert property (
    $changed(engine_clock_select) |-> $past(engine_halt, 2))
    else $error("clock select moved without earlier halt");
  a_halt_write: assert property (
    cfgw |=> engine_halt == $past(hwdata[HALT_BIT]))
    else $error("halt does not follow config write");
  a_halt_hold: assert property (!cfgw |=> $stable(engine_halt))
    else $error("halt changed without a write");
  a_lost_cause: assert property (
    frm_lost |-> frm_end_of_frame_bit_six && frm_match)
    else $error("frame lost without a matching frame");
  a_rdata_idle: assert property (!dph |-> hrdata == '0)
    else $error("read data outside data phase");
  a_irq_cause: assert property (
    $rose(irq) |-> $past(frm_end_of_frame_bit_six) || $past(dph) || $past(dph, 2))
    else $error("interrupt rose without a cause");
  c_select: cover property ($rose(engine_clock_select));
  c_irq: cover property ($rose(irq));
  c_lost: cover property (frm_lost);
endmodule : crb_rx_lock_monitor

bind crb_rx_lock crb_rx_lock_monitor #(.NSLOT(NSLOT), .SW(SW)) u_mon (.*);

// ---- tb/crb_can_node.sv ----
/*
  Far-side model: other nodes on the shared bus, seen as frame events.
  Assumes the bench calls sof and eof one after another.
*/
`timescale 1ns/1ps
module crb_can_node (
  // Clock
  input wire logic   hclk,
  // Frame events
  output logic        frm_start,
  output logic        frm_end_of_frame_bit_six,
  output logic        frm_match,
  output logic [3:0]  frm_slot,
  output logic [31:0] frm_data
);
  initial begin
    frm_start = 1'b0;
    frm_end_of_frame_bit_six  = 1'b0;
    frm_match = 1'b0;
    frm_slot  = 4'h0;
    frm_data  = 32'h0;
  end
  // First identifier bit
  task automatic sof();
    @(posedge hclk);
    frm_start <= 1'b1;
    @(posedge hclk);
    frm_start <= 1'b0;
  endtask : sof
  // Bit six of end of frame; lines flipped after so stale data never looks valid
  task automatic eof(input logic [3:0] s, input logic [31:0] d);
    @(posedge hclk);
    frm_end_of_frame_bit_six  <= 1'b1;
    frm_match <= 1'b1;
    frm_slot  <= s;
    frm_data  <= d;
    @(posedge hclk);
    frm_end_of_frame_bit_six  <= 1'b0;
    frm_match <= 1'b0;
    frm_slot  <= ~s;
    frm_data  <= ~d;
  endtask : eof
endmodule : crb_can_node

// ---- tb/crb_rx_lock_bench.sv ----
/*
  Self-checking bench for crb_rx_lock.
  Assumes the bound monitor and crb_can_node as frame source.
*/
`timescale 1ns/1ps
module crb_rx_lock_bench;
  import crb_pkg::*;
  // ****************************************
  // Harness
  // ****************************************
  logic        hclk, hresetn, hsel, hwrite, osc_tick, hrdy, hresp;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd, frm_data;
  logic        frm_start, frm_end_of_frame_bit_six, frm_match, halt, sel, frm_lost, irq;
  logic [3:0]  frm_slot;
  logic [15:0] ts_a, ca, cb;
  int          n_fail, comparisons, cyc;
  crb_rx_lock dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hrdy), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .frm_start(frm_start),
    .frm_end_of_frame_bit_six(frm_end_of_frame_bit_six), .frm_match(frm_match), .frm_slot(frm_slot),
    .frm_data(frm_data), .osc_tick(osc_tick), .engine_halt(halt),
    .engine_clock_select(sel), .frm_lost(frm_lost), .irq(irq));
  crb_can_node node (.hclk(hclk), .frm_start(frm_start), .frm_end_of_frame_bit_six(frm_end_of_frame_bit_six),
    .frm_match(frm_match), .frm_slot(frm_slot), .frm_data(frm_data));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // Oscillator five times slower, so back-to-back writes can share a period
  always @(posedge hclk) begin
    cyc      <= cyc + 1;
    osc_tick <= (cyc % 5 == 4);
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    htrans <= HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hrdy !== 1'b1);
    rd = hrdata;
    chk(32'(hresp), 32'h0);
  endtask : bus
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task automatic end_sim();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_clock();
    rdc(OFS_CTRL, 32'h0);
    rdc(12'h800, 32'h0);
    bus(1'b1, OFS_MODULE_CFG, 32'h1);
    bus(1'b1, OFS_CTRL, 32'h1);
    repeat (15) @(posedge hclk);
    rdc(OFS_CTRL, 32'h3);
    chk(32'(sel), 32'h1);
    chk(32'(halt), 32'h1);
    bus(1'b1, OFS_MODULE_CFG, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h0);
    repeat (15) @(posedge hclk);
    rdc(OFS_CTRL, 32'h2);
    bus(1'b1, OFS_MODULE_CFG, 32'h1);
    repeat (15) @(posedge hclk);
    rdc(OFS_CTRL, 32'h0);
    chk(32'(sel), 32'h0);
  endtask : t_clock
  task automatic t_frames();
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, OFS_SLOT_BASE + 12'(8 * i), 32'h0400_0000);
    end
    bus(1'b1, OFS_IRQ_MASK, 32'h1);
    node.sof();
    ca = 16'(cyc);
    node.eof(4'h0, 32'ha5a5_0001);
    rdc(OFS_DONE_FLAGS, 32'h1);
    chk(32'(irq), 32'h1);
    bus(1'b0, OFS_SLOT_BASE, 32'h0);
    chk(32'(rd[27:24]), 32'(CODE_RX_FULL));
    ts_a = rd[15:0];
    bus(1'b1, OFS_DONE_FLAGS, 32'h1);
    #1;
    chk(32'(irq), 32'h0);
    node.sof();
    cb = 16'(cyc);
    node.eof(4'h0, 32'h5a5a_0002);
    rdc(OFS_LOCK_STAT, 32'h0000_0300);
    rdc(OFS_SLOT_BASE + 12'h004, 32'ha5a5_0001);
    rdc(OFS_DONE_FLAGS, 32'h0);
    node.eof(4'h1, 32'h0000_0b0b);
    #1;
    chk(32'(irq), 32'h0);
    node.sof();
    bus(1'b0, OFS_TIMER, 32'h0);
    repeat (3) @(posedge hclk);
    rdc(OFS_LOCK_STAT, 32'h0);
    rdc(OFS_DONE_FLAGS, 32'h3);
    chk(32'(irq), 32'h1);
    bus(1'b0, OFS_SLOT_BASE, 32'h0);
    chk(32'(rd[15:0]), 32'(16'(ts_a + (cb - ca))));
    rdc(OFS_SLOT_BASE + 12'h004, 32'h5a5a_0002);
  endtask : t_frames
  task automatic t_queue();
    bus(1'b1, OFS_DONE_FLAGS, 32'h3);
    node.eof(4'h0, 32'h0000_0c0c);
    fork
      bus(1'b0, OFS_SLOT_BASE + 12'h008, 32'h0);
      begin
        @(posedge hclk);
        node.eof(4'h1, 32'h0000_0d0d);
      end
    join
    rdc(OFS_LOCK_STAT, 32'h0000_0501);
    rdc(OFS_SLOT_BASE + 12'h004, 32'h0000_0c0c);
    rdc(OFS_DONE_FLAGS, 32'h1);
    bus(1'b0, OFS_TIMER, 32'h0);
    repeat (3) @(posedge hclk);
    rdc(OFS_DONE_FLAGS, 32'h3);
    rdc(OFS_SLOT_BASE + 12'h00c, 32'h0000_0d0d);
  endtask : t_queue
  task automatic t_deact();
    repeat (40) @(posedge hclk);
    bus(1'b1, OFS_SLOT_BASE + 12'h008, 32'h0);
    bus(1'b1, OFS_DONE_FLAGS, 32'h3);
    node.eof(4'h1, 32'h0000_0e0e);
    rdc(OFS_DONE_FLAGS, 32'h0);
    bus(1'b0, OFS_SLOT_BASE + 12'h008, 32'h0);
    chk(32'(rd[27:24]), 32'(CODE_INACTIVE));
    bus(1'b0, OFS_TIMER, 32'h0);
    node.eof(4'h0, 32'h0000_0f0f);
    rdc(OFS_DONE_FLAGS, 32'h1);
    chk(32'(irq), 32'h1);
    rdc(OFS_SLOT_BASE + 12'h004, 32'h0000_0f0f);
  endtask : t_deact
  initial begin
    {hresetn, hsel, hwrite, osc_tick, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    n_fail = 0;
    comparisons = 0;
    cyc = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    hsel    <= 1'b1;
    t_clock();
    t_frames();
    t_queue();
    t_deact();
    end_sim();
  end
  // Whole run needs well under two thousand cycles
  initial begin
    #20000;
    n_fail++;
    end_sim();
  end
endmodule : crb_rx_lock_bench
